// *** rtl/rpe_pkg.sv ***
// Constants shared by both ends of the configuration port and the status bank.
// Assumes a single core clock and dword addressing of configuration space.
package rpe_pkg;

  // ----------------------------------------------------------------------
  // Port widths
  // ----------------------------------------------------------------------
  localparam int unsigned DW_ADDR_W = 10;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BE_W      = 4;

  // ----------------------------------------------------------------------
  // Configuration space layout (byte offsets, dword = byte / 4)
  // ----------------------------------------------------------------------
  localparam logic [11:0] CMD_STATUS_BYTE_OFF  = 12'h004;
  localparam logic [11:0] PRI_STATUS_BYTE_OFF  = 12'h006;
  localparam logic [11:0] SEC_STATUS_BYTE_OFF  = 12'h01E;
  localparam logic [11:0] BRIDGE_CTL_BYTE_OFF  = 12'h03E;
  localparam logic [9:0]  CMD_STATUS_DW = 10'(CMD_STATUS_BYTE_OFF >> 2);
  localparam logic [9:0]  SEC_STATUS_DW = 10'(SEC_STATUS_BYTE_OFF >> 2);
  localparam logic [9:0]  BRIDGE_CTL_DW = 10'(BRIDGE_CTL_BYTE_OFF >> 2);

  // Writable bits of the command and bridge control halves
  localparam logic [15:0] CMD_RW_MASK    = 16'h0546;
  localparam logic [15:0] BRIDGE_RW_MASK = 16'h0003;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam logic [15:0] BRIDGE_RESET   = 16'h0000;
  localparam int unsigned CMD_PER_BIT    = 6;
  localparam int unsigned CMD_SERR_BIT   = 8;
  localparam int unsigned BRG_PER_BIT    = 0;
  localparam int unsigned BRG_SERR_BIT   = 1;

  // Status halves: sticky error bits and hard-wired bits
  localparam logic [15:0] STATUS_ERR_MASK = 16'hF900;
  localparam logic [15:0] PRI_FIXED_ONES  = 16'h0010;
  localparam int unsigned ST_PARITY_BIT   = 8;
  localparam int unsigned ST_SIG_TA_BIT   = 11;
  localparam int unsigned ST_RCV_TA_BIT   = 12;
  localparam int unsigned ST_RCV_MA_BIT   = 13;
  localparam int unsigned ST_SYS_ERR_BIT  = 14;
  localparam int unsigned ST_DET_PAR_BIT  = 15;

  // ----------------------------------------------------------------------
  // Host controller register map (AHB-Lite, byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] HOST_CTRL_OFF   = 4'h0;
  localparam logic [3:0] HOST_WDATA_OFF  = 4'h4;
  localparam logic [3:0] HOST_RDATA_OFF  = 4'h8;
  localparam logic [3:0] HOST_STATUS_OFF = 4'hC;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_WRITE_BIT = 1;
  localparam int unsigned CTRL_BE_LSB    = 4;
  localparam int unsigned CTRL_ADDR_LSB  = 16;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_DONE_BIT  = 1;

  typedef enum logic {RPE_HOST_IDLE, RPE_HOST_ACCESS} rpe_host_state_t;

  // Expand byte enables into a bit mask
  function automatic logic [DATA_W-1:0] be_mask(input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : be_mask

endpackage : rpe_pkg

// *** rtl/rpe_cfg_if.sv ***
// Configuration management port joining user logic and the status bank.
// Assumes both ends share hclk; the bench instantiates and connects it.
`timescale 1ns/100ps
interface rpe_cfg_if;
  logic [rpe_pkg::DW_ADDR_W-1:0] dwaddr;
  logic [rpe_pkg::DATA_W-1:0]    config_write_word;
  logic [rpe_pkg::BE_W-1:0]      byte_en;
  logic                          rd_en;
  logic                          wr_en;
  logic [rpe_pkg::DATA_W-1:0]    rd_data;
  logic                          rd_wr_done;

  modport dev (input dwaddr, config_write_word, byte_en, rd_en, wr_en,
               output rd_data, rd_wr_done);
  modport usr (output dwaddr, config_write_word, byte_en, rd_en, wr_en,
               input rd_data, rd_wr_done);
endinterface : rpe_cfg_if

// *** rtl/rpe_rw1c_reg.sv ***
// Sticky write-one-to-clear bit group; a set in the clear cycle wins.
// Assumes set and clr are single-cycle qualified pulses.
`timescale 1ns/100ps
module rpe_rw1c_reg #(
  parameter int unsigned      WIDTH = 16,
  parameter logic [WIDTH-1:0] IMPL  = '1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] q
);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= ((q & ~clr) | set) & IMPL;
    end
  end

endmodule : rpe_rw1c_reg

// *** rtl/rpe_status_dev.sv ***
// Root-port status bank with the configuration management port.
// Assumes packet-layer event inputs are one-cycle pulses on hclk and that
// the user end holds a request until done, as the port requires.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module rpe_status_dev (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  rpe_cfg_if.dev      cfg,
  input  wire logic   poison_cpl_rx,
  input  wire logic   poison_any_rx,
  input  wire logic   poison_wr_tx,
  input  wire logic   poison_down_tx,
  input  wire logic   err_msg_rx,
  input  wire logic   err_msg_up_req,
  input  wire logic   user_cpl_abort,
  input  wire logic   cpl_ca_rx,
  input  wire logic   cpl_ur_rx,
  output logic [15:0] primary_error_status,
  output logic [15:0] secondary_error_status,
  output logic [15:0] command_q,
  output logic [15:0] bridge_control_q
);

  // ----------------------------------------------------------------------
  // Access acceptance
  // ----------------------------------------------------------------------
  logic        done_q;
  logic        accept;
  logic        wr_accept;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] rd_d;
  logic [15:0] pri_set;
  logic [15:0] pri_clr;
  logic [15:0] sec_set;
  logic [15:0] sec_clr;
  logic [15:0] pri_err;
  logic [15:0] sec_err;

  // request held until done; ignored in the done cycle
  assign accept    = (cfg.rd_en | cfg.wr_en) & ~done_q;
  assign wr_accept = accept & cfg.wr_en;
  assign wmask     = rpe_pkg::be_mask(cfg.byte_en);
  assign wbits     = cfg.config_write_word & wmask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= accept;
    end
  end

  // ----------------------------------------------------------------------
  // Command and bridge control
  // ----------------------------------------------------------------------
  // only RW bits change, within enabled bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      command_q <= rpe_pkg::CMD_RESET;
    end else if (wr_accept && cfg.dwaddr == rpe_pkg::CMD_STATUS_DW) begin
      command_q <= (command_q & ~(wmask[15:0] & rpe_pkg::CMD_RW_MASK))
                 | (wbits[15:0] & rpe_pkg::CMD_RW_MASK);
    end
  end

  // bridge control lives in the upper half of its dword
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bridge_control_q <= rpe_pkg::BRIDGE_RESET;
    end else if (wr_accept && cfg.dwaddr == rpe_pkg::BRIDGE_CTL_DW) begin
      bridge_control_q <= (bridge_control_q & ~(wmask[31:16] & rpe_pkg::BRIDGE_RW_MASK))
                        | (wbits[31:16] & rpe_pkg::BRIDGE_RW_MASK);
    end
  end

  // ----------------------------------------------------------------------
  // Status set events
  // ----------------------------------------------------------------------
  logic cmd_per;
  logic cmd_serr;
  logic brg_per;
  logic brg_serr;

  assign cmd_per  = command_q[rpe_pkg::CMD_PER_BIT];
  assign cmd_serr = command_q[rpe_pkg::CMD_SERR_BIT];
  assign brg_per  = bridge_control_q[rpe_pkg::BRG_PER_BIT];
  assign brg_serr = bridge_control_q[rpe_pkg::BRG_SERR_BIT];

  always_comb begin
    pri_set = '0;
    sec_set = '0;
    pri_set[rpe_pkg::ST_PARITY_BIT]  = poison_cpl_rx & cmd_per;
    // abort bits have no set source
    pri_set[rpe_pkg::ST_SIG_TA_BIT]  = 1'b0;
    pri_set[rpe_pkg::ST_RCV_TA_BIT]  = 1'b0;
    pri_set[rpe_pkg::ST_RCV_MA_BIT]  = 1'b0;
    pri_set[rpe_pkg::ST_SYS_ERR_BIT] = (err_msg_rx & cmd_serr & brg_serr)
                                     | (err_msg_up_req & cmd_serr);
    pri_set[rpe_pkg::ST_DET_PAR_BIT] = poison_down_tx;
    sec_set[rpe_pkg::ST_PARITY_BIT]  = brg_per & (poison_cpl_rx | poison_wr_tx);
    sec_set[rpe_pkg::ST_SIG_TA_BIT]  = user_cpl_abort;
    sec_set[rpe_pkg::ST_RCV_TA_BIT]  = cpl_ca_rx;
    sec_set[rpe_pkg::ST_RCV_MA_BIT]  = cpl_ur_rx;
    sec_set[rpe_pkg::ST_SYS_ERR_BIT] = err_msg_rx;
    sec_set[rpe_pkg::ST_DET_PAR_BIT] = poison_any_rx;
  end

  // write-one clears within enabled upper bytes
  assign pri_clr = (wr_accept && cfg.dwaddr == rpe_pkg::CMD_STATUS_DW)
                   ? wbits[31:16] : 16'h0000;
  assign sec_clr = (wr_accept && cfg.dwaddr == rpe_pkg::SEC_STATUS_DW)
                   ? wbits[31:16] : 16'h0000;

  rpe_rw1c_reg #(
    .WIDTH (16),
    .IMPL  (rpe_pkg::STATUS_ERR_MASK)
  ) u_pri (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (pri_set),
    .clr     (pri_clr),
    .q       (pri_err)
  );

  rpe_rw1c_reg #(
    .WIDTH (16),
    .IMPL  (rpe_pkg::STATUS_ERR_MASK)
  ) u_sec (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (sec_set),
    .clr     (sec_clr),
    .q       (sec_err)
  );

  // reserved and interrupt bits zero, capabilities one
  assign primary_error_status   = pri_err | rpe_pkg::PRI_FIXED_ONES;
  assign secondary_error_status = sec_err;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unimplemented dwords read zero; root port exposes no other state here
  always_comb begin
    unique case (cfg.dwaddr)
      rpe_pkg::CMD_STATUS_DW: rd_d = {primary_error_status, command_q};
      rpe_pkg::SEC_STATUS_DW: rd_d = {secondary_error_status, 16'h0000};
      rpe_pkg::BRIDGE_CTL_DW: rd_d = {bridge_control_q, 16'h0000};
      default:                rd_d = 32'h0000_0000;
    endcase
  end

  // data captured with the access, valid with done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg.rd_data <= 32'h0000_0000;
    end else if (accept && cfg.rd_en) begin
      cfg.rd_data <= rd_d;
    end
  end

  assign cfg.rd_wr_done = done_q;

endmodule : rpe_status_dev

// *** rtl/rpe_cfg_host.sv ***
// User-side controller of the configuration port, commanded over AHB-Lite.
// Assumes a single AHB-Lite master with whole-word single transfers.
`timescale 1ns/100ps
module rpe_cfg_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  rpe_cfg_if.usr           cfg
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  rpe_pkg::rpe_host_state_t state_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [3:0]  addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        done_flag_q;
  logic        addr_phase;
  logic        ctrl_wr;
  logic        start;

  assign addr_phase = hsel & htrans[1] & hready;
  assign ctrl_wr    = wr_pend_q && addr_q == rpe_pkg::HOST_CTRL_OFF;
  assign start      = ctrl_wr && hwdata[rpe_pkg::CTRL_START_BIT]
                      && state_q == rpe_pkg::RPE_HOST_IDLE;

  // Reads take one wait state so a preceding write is always visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 4'h0;
      hreadyout <= 1'b1;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      rd_pend_q <= addr_phase & ~hwrite;
      hreadyout <= ~(addr_phase & ~hwrite);
      if (addr_phase) begin
        addr_q <= haddr[3:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      unique case (addr_q)
        rpe_pkg::HOST_WDATA_OFF:  hrdata <= wdata_q;
        rpe_pkg::HOST_RDATA_OFF:  hrdata <= rdata_q;
        rpe_pkg::HOST_STATUS_OFF: hrdata <= {30'h0, done_flag_q,
                                             state_q == rpe_pkg::RPE_HOST_ACCESS};
        default:                  hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdata_q <= 32'h0000_0000;
    end else if (wr_pend_q && addr_q == rpe_pkg::HOST_WDATA_OFF) begin
      wdata_q <= hwdata;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration port sequencer
  // ----------------------------------------------------------------------
  // software supplies dword addresses; the host never scales
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q               <= rpe_pkg::RPE_HOST_IDLE;
      cfg.rd_en             <= 1'b0;
      cfg.wr_en             <= 1'b0;
      cfg.dwaddr            <= '0;
      cfg.byte_en           <= '0;
      cfg.config_write_word <= '0;
      rdata_q               <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        rpe_pkg::RPE_HOST_IDLE: begin
          if (start) begin
            state_q               <= rpe_pkg::RPE_HOST_ACCESS;
            cfg.wr_en             <= hwdata[rpe_pkg::CTRL_WRITE_BIT];
            cfg.rd_en             <= ~hwdata[rpe_pkg::CTRL_WRITE_BIT];
            cfg.byte_en           <= hwdata[rpe_pkg::CTRL_BE_LSB +: rpe_pkg::BE_W];
            cfg.dwaddr            <= hwdata[rpe_pkg::CTRL_ADDR_LSB +: rpe_pkg::DW_ADDR_W];
            cfg.config_write_word <= wdata_q;
          end
        end
        rpe_pkg::RPE_HOST_ACCESS: begin
          // read data taken with the done strobe
          if (cfg.rd_wr_done) begin
            state_q   <= rpe_pkg::RPE_HOST_IDLE;
            cfg.rd_en <= 1'b0;
            cfg.wr_en <= 1'b0;
            if (cfg.rd_en) begin
              rdata_q <= cfg.rd_data;
            end
          end
        end
      endcase
    end
  end

  // Done flag: write one clears, a completion in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_flag_q <= 1'b0;
    end else if (state_q == rpe_pkg::RPE_HOST_ACCESS && cfg.rd_wr_done) begin
      done_flag_q <= 1'b1;
    end else if (wr_pend_q && addr_q == rpe_pkg::HOST_STATUS_OFF
                 && hwdata[rpe_pkg::STAT_DONE_BIT]) begin
      done_flag_q <= 1'b0;
    end
  end

endmodule : rpe_cfg_host

// *** dv/rpe_cfg_chk.sv ***
// Concurrent checks on the configuration port between host and bank.
// Assumes it watches the one rpe_cfg_if that joins the two design ends.
`timescale 1ns/100ps
module rpe_cfg_chk (
  input wire logic                          hclk,
  input wire logic                          hresetn,
  input wire logic [rpe_pkg::DW_ADDR_W-1:0] dwaddr,
  input wire logic [rpe_pkg::DATA_W-1:0]    config_write_word,
  input wire logic [rpe_pkg::BE_W-1:0]      byte_en,
  input wire logic                          rd_en,
  input wire logic                          wr_en,
  input wire logic [rpe_pkg::DATA_W-1:0]    rd_data,
  input wire logic                          rd_wr_done
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------------
  // Request taken, read taken
  // ----------------------------------------------------------------------
  sequence s_take;
    (rd_en || wr_en) && !rd_wr_done;
  endsequence
  sequence s_rd_take;
    rd_en && !rd_wr_done;
  endsequence

  a_done_follows: assert property (s_take |=> rd_wr_done)
    else $error("done missing one cycle after request");
  a_done_pulse: assert property (rd_wr_done |=> !rd_wr_done)
    else $error("done longer than one cycle");
  a_no_stray_done: assert property (!(rd_en || wr_en) |=> !rd_wr_done)
    else $error("done without request");
  a_req_held: assert property (s_take |=>
    $stable({rd_en, wr_en, dwaddr, config_write_word, byte_en}))
    else $error("request changed before done");
  a_one_kind: assert property (!(rd_en && wr_en))
    else $error("read and write together");
  a_rdata_moves: assert property ($changed(rd_data) |-> rd_wr_done && $past(rd_en))
    else $error("read data changed outside read done");
  // Reserved zero, capabilities one, interrupt bit zero
  a_status_fixed: assert property (s_rd_take ##0 (dwaddr == rpe_pkg::CMD_STATUS_DW) |=>
    ((rd_data[31:16] & 16'h06EF) == 16'h0000) && rd_data[20])
    else $error("status fixed bits wrong");
  a_sec_reserved: assert property (s_rd_take ##0 (dwaddr == rpe_pkg::SEC_STATUS_DW) |=>
    (rd_data & 32'h06FF_FFFF) == 32'h0000_0000)
    else $error("secondary reserved bits not zero");
  a_unmapped_zero: assert property (s_rd_take ##0 (dwaddr != rpe_pkg::CMD_STATUS_DW) &&
    (dwaddr != rpe_pkg::SEC_STATUS_DW) && (dwaddr != rpe_pkg::BRIDGE_CTL_DW) |=>
    rd_data == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule : rpe_cfg_chk

// *** dv/test_root_port_error_status_cfg_access.sv ***
// Self-checking bench: an AHB-Lite master drives the host, pulses drive the bank.
// Assumes both design ends meet through one rpe_cfg_if instance.
`timescale 1ns/100ps
module test_root_port_error_status_cfg_access;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] brg;
    logic [8:0]  ev;
    logic [15:0] pri;
    logic [15:0] sec;
  } rpe_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [8:0]  ev = 9'h000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] pri_st;
  logic [15:0] sec_st;
  logic [15:0] cmd_q;
  logic [15:0] brg_q;
  logic [31:0] d;
  int          miscompares = 0;
  int          checked = 0;
  // Event bits: cpl poison, any poison, wr poison, down poison, msg, up, abort, CA, UR
  rpe_row_t    rows [13] = '{
    '{16'h0040, 16'h0000, 9'h100, 16'h0110, 16'h0000},
    '{16'h0000, 16'h0001, 9'h100, 16'h0010, 16'h0100},
    '{16'h0000, 16'h0001, 9'h040, 16'h0010, 16'h0100},
    '{16'h0000, 16'h0000, 9'h080, 16'h0010, 16'h8000},
    '{16'h0000, 16'h0000, 9'h020, 16'h8010, 16'h0000},
    '{16'h0100, 16'h0002, 9'h010, 16'h4010, 16'h4000},
    '{16'h0100, 16'h0000, 9'h010, 16'h0010, 16'h4000},
    '{16'h0100, 16'h0000, 9'h008, 16'h4010, 16'h0000},
    '{16'h0000, 16'h0003, 9'h008, 16'h0010, 16'h0000},
    '{16'h0000, 16'h0000, 9'h004, 16'h0010, 16'h0800},
    '{16'h0000, 16'h0000, 9'h002, 16'h0010, 16'h1000},
    '{16'h0000, 16'h0000, 9'h001, 16'h0010, 16'h2000},
    '{16'hFFFF, 16'hFFFF, 9'h1FF, 16'hC110, 16'hF900}
  };

  always #5 hclk = ~hclk;

  rpe_cfg_if i_rpe_cfg_if ();
  // Single slave, so its ready is the bus ready
  rpe_cfg_host i_rpe_cfg_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cfg(i_rpe_cfg_if));
  rpe_status_dev i_rpe_status_dev (.hclk(hclk), .hresetn(hresetn), .cfg(i_rpe_cfg_if),
    .poison_cpl_rx(ev[8]), .poison_any_rx(ev[7]), .poison_wr_tx(ev[6]),
    .poison_down_tx(ev[5]), .err_msg_rx(ev[4]), .err_msg_up_req(ev[3]),
    .user_cpl_abort(ev[2]), .cpl_ca_rx(ev[1]), .cpl_ur_rx(ev[0]),
    .primary_error_status(pri_st), .secondary_error_status(sec_st),
    .command_q(cmd_q), .bridge_control_q(brg_q));
  rpe_cfg_chk i_rpe_cfg_chk (.hclk(hclk), .hresetn(hresetn),
    .dwaddr(i_rpe_cfg_if.dwaddr), .config_write_word(i_rpe_cfg_if.config_write_word),
    .byte_en(i_rpe_cfg_if.byte_en), .rd_en(i_rpe_cfg_if.rd_en),
    .wr_en(i_rpe_cfg_if.wr_en), .rd_data(i_rpe_cfg_if.rd_data),
    .rd_wr_done(i_rpe_cfg_if.rd_wr_done));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp16

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp32

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Full host round trip: load, start, poll done, clear done, fetch result
  task automatic cfg_op(input logic wr, input logic [3:0] be, input logic [9:0] dw,
                        input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] s;
    ahb(1'b1, 32'h4, wd, s);
    ahb(1'b1, 32'h0, {6'h00, dw, 8'h00, be, 2'h0, wr, 1'b1}, s);
    do ahb(1'b0, 32'hC, 32'h0, s); while (s[1] !== 1'b1);
    cmp32(s, 32'h0000_0002, "host status");
    ahb(1'b1, 32'hC, 32'h2, s);
    ahb(1'b0, 32'h8, 32'h0, rd);
  endtask : cfg_op

  task automatic pulse(input logic [8:0] e);
    ev <= e;
    @(posedge hclk);
    ev <= 9'h000;
    @(posedge hclk);
  endtask : pulse

  task automatic finish_test;
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 13; i++) begin
      cfg_op(1'b1, 4'hF, rpe_pkg::CMD_STATUS_DW, {16'hFFFF, rows[i].cmd}, d);
      cfg_op(1'b1, 4'hC, rpe_pkg::BRIDGE_CTL_DW, {rows[i].brg, 16'h0000}, d);
      cfg_op(1'b1, 4'hC, rpe_pkg::SEC_STATUS_DW, 32'hFFFF_0000, d);
      pulse(rows[i].ev);
      cmp16(pri_st, rows[i].pri, "primary");
      cmp16(sec_st, rows[i].sec, "secondary");
      cmp16(cmd_q, rows[i].cmd & rpe_pkg::CMD_RW_MASK, "command");
      cmp16(brg_q, rows[i].brg & rpe_pkg::BRIDGE_RW_MASK, "bridge");
      cfg_op(1'b0, 4'h0, rpe_pkg::CMD_STATUS_DW, 32'h0, d);
      cmp32(d, {rows[i].pri, rows[i].cmd & rpe_pkg::CMD_RW_MASK}, "dw status");
      cfg_op(1'b0, 4'h0, rpe_pkg::SEC_STATUS_DW, 32'h0, d);
      cmp32(d, {rows[i].sec, 16'h0000}, "dw secondary");
      $display("row %0d done", i);
    end
    cfg_op(1'b1, 4'hC, rpe_pkg::CMD_STATUS_DW, 32'h0000_0000, d);
    cmp16(pri_st, 16'hC110, "zero write");
    cfg_op(1'b1, 4'h8, rpe_pkg::CMD_STATUS_DW, 32'h4000_0000, d);
    cmp16(pri_st, 16'h8110, "clear bit 14");
    cfg_op(1'b1, 4'hC, rpe_pkg::SEC_STATUS_DW, 32'hFFFF_0000, d);
    pulse(9'h006);
    cmp16(sec_st, 16'h1800, "two sets");
    cfg_op(1'b1, 4'h4, rpe_pkg::SEC_STATUS_DW, 32'hFFFF_FFFF, d);
    cmp16(sec_st, 16'h1800, "low lane");
    cfg_op(1'b1, 4'h8, rpe_pkg::SEC_STATUS_DW, 32'h0800_0000, d);
    cmp16(sec_st, 16'h1000, "clear bit 11");
    // Clear and set of bit 15 meet at the edge that takes the access
    fork
      cfg_op(1'b1, 4'h8, rpe_pkg::SEC_STATUS_DW, 32'h8000_0000, d);
      begin
        repeat (4) @(posedge hclk);
        pulse(9'h080);
      end
    join
    cmp16(sec_st, 16'h9000, "set beats clear");
    $display("byte lane test done");
    cfg_op(1'b1, 4'hF, 10'h002, 32'hFFFF_FFFF, d);
    cfg_op(1'b0, 4'h0, 10'h002, 32'h0, d);
    cmp32(d, 32'h0000_0000, "unmapped dword");
    ahb(1'b0, 32'h10, 32'h0, d);
    cmp32(d, 32'h0000_0000, "unmapped host");
    cmp16({15'h0, hresp}, 16'h0000, "response okay");
    $display("unmapped test done");
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    cmp16(pri_st, 16'h0010, "primary in reset");
    cmp16(sec_st, 16'h0000, "secondary in reset");
    cmp16(cmd_q, 16'h0000, "command in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    cfg_op(1'b0, 4'h0, rpe_pkg::CMD_STATUS_DW, 32'h0, d);
    cmp32(d, 32'h0010_0000, "status after reset");
    $display("reset test done");
    finish_test();
  end

  // Whole run needs little more than a thousand cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    finish_test();
  end
endmodule : test_root_port_error_status_cfg_access
